// >>> logic/dpr_decoder.sv
// Paged register window of the acquisition controller on ISA I/O cycles
`default_nettype none
module dpr_decoder
  import dpr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_window_en,
  input  wire logic [2:0]  i_base_sel,
  input  wire logic [9:0]  i_sa,
  input  wire logic        i_aen,
  input  wire logic        i_ior_n,
  input  wire logic        i_iow_n,
  input  wire logic [7:0]  i_sd,
  output logic      [7:0]  o_sd,
  output logic             o_sd_oe,
  output logic             o_claim,
  input  wire dpr_status_s i_status,
  output dpr_cfg_s         o_cfg,
  output dpr_strobe_s      o_strobe
);

  // Base address for a selection index
  function automatic logic [9:0] base_of(input logic [2:0] sel);
    base_of = BASE_FIRST + (10'(sel) * BASE_STEP);
  endfunction : base_of

  // Keep writable positions, clear reserved ones
  function automatic logic [7:0] keep(input logic [7:0] d,
                                      input logic [7:0] m);
    keep = d & m;
  endfunction : keep

  logic [2:0]  base_reg;
  logic [9:0]  base_addr;
  logic        strap_done_reg;
  logic        ior_n_reg;
  logic        iow_n_reg;
  logic        hit;
  logic        wr_pulse;
  logic        rd_pulse;
  logic [3:0]  ofs;
  logic [7:0]  rd_next;
  dpr_cfg_s    cfg_reg;
  dpr_strobe_s strobe_reg;
  logic        soft_clear;

  // Strap caught after release; reset holds the default selection
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      base_reg       <= BASE_SEL_DEFAULT;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      base_reg       <= i_base_sel;
      strap_done_reg <= 1'b1;
    end
  end

  // Strobe edge history for one action per bus cycle
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ior_n_reg <= 1'b1;
      iow_n_reg <= 1'b1;
    end else begin
      ior_n_reg <= i_ior_n;
      iow_n_reg <= i_iow_n;
    end
  end

  // Address decode; DMA cycles (AEN high) are never ours
  assign base_addr = base_of(base_reg);
  assign ofs = i_sa[OFS_BITS-1:0];
  assign hit = i_window_en && !i_aen &&
               (i_sa[9:OFS_BITS] == base_addr[9:OFS_BITS]);
  assign o_claim  = hit && (!i_ior_n || !i_iow_n);
  assign wr_pulse = hit && !i_iow_n && iow_n_reg;
  assign rd_pulse = hit && !i_ior_n && ior_n_reg;

  // Board reset command clears everything but the D/A settings
  assign soft_clear = strobe_reg.cmd.whole_board_reset;

  // Main registers, offsets 1 to 5 and 8 to 11
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_reg.bank_sel     <= PAGE_COUNTER;
      cfg_reg.chan_range   <= REG_RESET;
      cfg_reg.scan_enable  <= 1'b0;
      cfg_reg.adc_gain     <= 2'h0;
      cfg_reg.irq_ctrl     <= REG_RESET;
      cfg_reg.fifo_thresh  <= 11'h000;
      cfg_reg.port_a_out   <= REG_RESET;
      cfg_reg.port_b_out   <= REG_RESET;
      cfg_reg.port_c_out   <= REG_RESET;
      cfg_reg.dio_dac_ctrl <= REG_RESET;
    end else if (soft_clear) begin
      cfg_reg.bank_sel     <= PAGE_COUNTER;
      cfg_reg.chan_range   <= REG_RESET;
      cfg_reg.scan_enable  <= 1'b0;
      cfg_reg.adc_gain     <= 2'h0;
      cfg_reg.irq_ctrl     <= REG_RESET;
      cfg_reg.fifo_thresh  <= 11'h000;
      cfg_reg.port_a_out   <= REG_RESET;
      cfg_reg.port_b_out   <= REG_RESET;
      cfg_reg.port_c_out   <= REG_RESET;
      cfg_reg.dio_dac_ctrl <= REG_RESET;
    end else if (wr_pulse) begin
      unique case (ofs)
        OFS_BANK:      cfg_reg.bank_sel <= i_sd[1:0];
        OFS_RANGE:     cfg_reg.chan_range <= i_sd;
        OFS_GAIN_SCAN: begin
          cfg_reg.scan_enable <= i_sd[2];
          cfg_reg.adc_gain    <= i_sd[1:0];
        end
        OFS_IRQ_CTR:   cfg_reg.irq_ctrl <= keep(i_sd, MASK_IRQ_CTR);
        OFS_THRESH: begin
          if (cfg_reg.expanded_fifo_mode) begin
            cfg_reg.fifo_thresh[10:3] <= i_sd;
          end else begin
            cfg_reg.fifo_thresh <= {5'h00, i_sd[5:0]};
          end
        end
        OFS_PORT_A:    cfg_reg.port_a_out <= i_sd;
        OFS_PORT_B:    cfg_reg.port_b_out <= i_sd;
        OFS_PORT_C:    cfg_reg.port_c_out <= i_sd;
        OFS_DIO_DAC:   cfg_reg.dio_dac_ctrl <= keep(i_sd, MASK_DIO_DAC);
        default: ;
      endcase
    end
  end

  // D/A data and channel survive the board reset command
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_reg.dac_data    <= 16'h0000;
      cfg_reg.dac_channel <= 2'h0;
    end else if (wr_pulse) begin
      if (ofs == OFS_DAC_LOW) begin
        cfg_reg.dac_data[7:0] <= i_sd;
      end else if (ofs == OFS_DAC_HIGH) begin
        cfg_reg.dac_channel    <= i_sd[7:6];
        cfg_reg.dac_data[11:8] <= i_sd[3:0];
      end else if (ofs == OFS_PAGED3 &&
                   cfg_reg.bank_sel == PAGE_CONFIG) begin
        cfg_reg.dac_data[15:8] <= i_sd;
      end
    end
  end

  // Paged registers; the live page register picks the bank
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_reg.counter_byte       <= 24'h000000;
      cfg_reg.cal_data           <= REG_RESET;
      cfg_reg.cal_addr           <= REG_RESET;
      cfg_reg.cal_ctrl           <= REG_RESET;
      cfg_reg.expanded_fifo_mode <= 1'b0;
      cfg_reg.adc_mode           <= REG_RESET;
      cfg_reg.dac_mode           <= REG_RESET;
    end else if (soft_clear) begin
      cfg_reg.counter_byte       <= 24'h000000;
      cfg_reg.cal_data           <= REG_RESET;
      cfg_reg.cal_addr           <= REG_RESET;
      cfg_reg.cal_ctrl           <= REG_RESET;
      cfg_reg.expanded_fifo_mode <= 1'b0;
      cfg_reg.adc_mode           <= REG_RESET;
    end else if (wr_pulse && ofs >= OFS_PAGED0) begin
      unique case (cfg_reg.bank_sel)
        PAGE_COUNTER: begin
          if (ofs == OFS_PAGED0) cfg_reg.counter_byte[7:0] <= i_sd;
          if (ofs == OFS_PAGED1) cfg_reg.counter_byte[15:8] <= i_sd;
          if (ofs == OFS_PAGED2) cfg_reg.counter_byte[23:16] <= i_sd;
        end
        PAGE_CALIB: begin
          if (ofs == OFS_PAGED0) cfg_reg.cal_data <= i_sd;
          if (ofs == OFS_PAGED1) cfg_reg.cal_addr <= i_sd;
          if (ofs == OFS_PAGED2) begin
            cfg_reg.cal_ctrl <= keep(i_sd, MASK_CAL_CTRL);
          end
        end
        PAGE_CONFIG: begin
          if (ofs == OFS_PAGED0) begin
            cfg_reg.expanded_fifo_mode <= i_sd[0];
          end
          if (ofs == OFS_PAGED1) begin
            cfg_reg.adc_mode <= keep(i_sd, MASK_ADC_MODE);
          end
          if (ofs == OFS_PAGED2) begin
            cfg_reg.dac_mode <= keep(i_sd, MASK_DAC_MODE);
          end
        end
        default: ;  // Page 3 is empty; writes vanish
      endcase
    end
  end

  // One-cycle strobes; each command bit fires only its own function
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      strobe_reg <= '0;
    end else begin
      strobe_reg <= '0;
      if (wr_pulse) begin
        strobe_reg.wr_data <= i_sd;
        if (ofs == OFS_COMMAND) begin
          strobe_reg.cmd.convert_trigger   <= i_sd[7];
          strobe_reg.cmd.whole_board_reset <= i_sd[6];
          strobe_reg.cmd.dac_reset_cmd     <= i_sd[5];
          strobe_reg.cmd.fifo_clear        <= i_sd[4];
          strobe_reg.cmd.timer_irq_clear   <= i_sd[2];
          strobe_reg.cmd.dio_irq_clear     <= i_sd[1];
          strobe_reg.cmd.analog_irq_clear  <= i_sd[0];
        end
        if (ofs == OFS_PAGED3) begin
          strobe_reg.counter_ctl_wr <= cfg_reg.bank_sel == PAGE_COUNTER;
          strobe_reg.cal_key_wr     <= cfg_reg.bank_sel == PAGE_CALIB;
          strobe_reg.dac_upper_wr   <= cfg_reg.bank_sel == PAGE_CONFIG;
        end
      end
      // Reading page 2 offset 15 fires the simultaneous D/A update
      if (rd_pulse && ofs == OFS_PAGED3 &&
          cfg_reg.bank_sel == PAGE_CONFIG) begin
        strobe_reg.dac_sim_update <= 1'b1;
      end
    end
  end

  // Read multiplexer; every undefined position is a zero
  always_comb begin
    rd_next = 8'h00;
    unique case (ofs)
      OFS_COMMAND:   rd_next = i_status.adc_data[7:0];
      OFS_BANK:      rd_next = i_status.adc_data[15:8];
      OFS_RANGE:     rd_next = cfg_reg.chan_range;
      OFS_GAIN_SCAN: rd_next = {i_status.adc_busy, i_status.se_diff,
                                i_status.adc_wait, i_status.dac_busy,
                                i_status.fifo_over, cfg_reg.scan_enable,
                                cfg_reg.adc_gain};
      OFS_IRQ_CTR:   rd_next = cfg_reg.irq_ctrl;
      OFS_THRESH: begin
        if (cfg_reg.expanded_fifo_mode) begin
          rd_next = i_status.fifo_depth[7:0];
        end else begin
          rd_next = {2'h0, cfg_reg.fifo_thresh[5:0]};
        end
      end
      OFS_DAC_LOW: begin
        if (cfg_reg.expanded_fifo_mode) begin
          rd_next = {i_status.fifo_depth[11:8], i_status.fifo_over,
                     i_status.fifo_full, i_status.fifo_half,
                     i_status.fifo_empty};
        end else begin
          rd_next = {2'h0, i_status.fifo_depth[5:0]};
        end
      end
      OFS_DAC_HIGH:  rd_next = {1'b0, i_status.timer_irq, i_status.dio_irq,
                                i_status.analog_irq,
                                i_status.adc_chan};
      OFS_PORT_A:    rd_next = i_status.port_a_in;
      OFS_PORT_B:    rd_next = i_status.port_b_in;
      OFS_PORT_C:    rd_next = i_status.port_c_in;
      OFS_DIO_DAC:   rd_next = cfg_reg.dio_dac_ctrl;
      default: begin
        unique case (cfg_reg.bank_sel)
          PAGE_COUNTER: begin
            if (ofs == OFS_PAGED0) rd_next = i_status.counter_rd[7:0];
            if (ofs == OFS_PAGED1) rd_next = i_status.counter_rd[15:8];
            if (ofs == OFS_PAGED2) rd_next = i_status.counter_rd[23:16];
            if (ofs == OFS_PAGED3) rd_next = i_status.revision;
          end
          PAGE_CALIB: begin
            if (ofs == OFS_PAGED0) rd_next = cfg_reg.cal_data;
            if (ofs == OFS_PAGED1) rd_next = cfg_reg.cal_addr;
            if (ofs == OFS_PAGED2) begin
              rd_next = {1'b0, i_status.cal_td_busy, i_status.cal_ee_busy,
                         cfg_reg.cal_ctrl[4], 4'h0};
            end
          end
          PAGE_CONFIG: begin
            if (ofs == OFS_PAGED0) begin
              rd_next = {7'h00, cfg_reg.expanded_fifo_mode};
            end
            if (ofs == OFS_PAGED1) begin
              rd_next = {cfg_reg.dac_mode[7], cfg_reg.dac_mode[5:4], 1'b0,
                         cfg_reg.adc_mode[3], 1'b0, cfg_reg.adc_mode[1],
                         1'b0};
            end
            if (ofs == OFS_PAGED2) begin
              rd_next = {3'h0, i_status.dac_size, cfg_reg.dac_mode[3], 1'b0,
                         cfg_reg.dac_mode[1:0]};
            end
          end
          default: rd_next = 8'h00;
        endcase
      end
    endcase
  end

  // Read data and drive enable from flops, one cycle behind the strobe
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sd    <= 8'h00;
      o_sd_oe <= 1'b0;
    end else begin
      o_sd_oe <= hit && !i_ior_n;
      o_sd    <= (hit && !i_ior_n) ? rd_next : 8'h00;
    end
  end

  assign o_cfg    = cfg_reg;
  assign o_strobe = strobe_reg;

endmodule : dpr_decoder
`default_nettype wire

// >>> logic/dpr_pkg.sv
// Package: offsets, masks, reset values and carriers of the register window
`default_nettype none
package dpr_pkg;
  // Window placement on the ISA I/O space
  localparam logic [9:0] BASE_FIRST       = 10'h200;
  localparam logic [9:0] BASE_STEP        = 10'h040;
  localparam logic [2:0] BASE_SEL_DEFAULT = 3'h2;   // 0x280
  localparam int         OFS_BITS         = 4;      // 16-byte window

  // Register offsets
  localparam logic [3:0] OFS_COMMAND   = 4'h0;
  localparam logic [3:0] OFS_BANK      = 4'h1;
  localparam logic [3:0] OFS_RANGE     = 4'h2;
  localparam logic [3:0] OFS_GAIN_SCAN = 4'h3;
  localparam logic [3:0] OFS_IRQ_CTR   = 4'h4;
  localparam logic [3:0] OFS_THRESH    = 4'h5;
  localparam logic [3:0] OFS_DAC_LOW   = 4'h6;
  localparam logic [3:0] OFS_DAC_HIGH  = 4'h7;
  localparam logic [3:0] OFS_PORT_A    = 4'h8;
  localparam logic [3:0] OFS_PORT_B    = 4'h9;
  localparam logic [3:0] OFS_PORT_C    = 4'hA;
  localparam logic [3:0] OFS_DIO_DAC   = 4'hB;
  localparam logic [3:0] OFS_PAGED0    = 4'hC;
  localparam logic [3:0] OFS_PAGED1    = 4'hD;
  localparam logic [3:0] OFS_PAGED2    = 4'hE;
  localparam logic [3:0] OFS_PAGED3    = 4'hF;

  // Banks behind offsets 12 to 15
  localparam logic [1:0] PAGE_COUNTER = 2'h0;
  localparam logic [1:0] PAGE_CALIB   = 2'h1;
  localparam logic [1:0] PAGE_CONFIG  = 2'h2;

  // Writable bit masks; all other positions are reserved
  localparam logic [7:0] MASK_IRQ_CTR  = 8'hF7;
  localparam logic [7:0] MASK_DIO_DAC  = 8'hFB;
  localparam logic [7:0] MASK_CAL_CTRL = 8'hF8;
  localparam logic [7:0] MASK_ADC_MODE = 8'h0A;
  localparam logic [7:0] MASK_DAC_MODE = 8'hBB;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // Commands launched by writing ones at offset 0
  typedef struct packed {
    logic convert_trigger;
    logic whole_board_reset;
    logic dac_reset_cmd;
    logic fifo_clear;
    logic timer_irq_clear;
    logic dio_irq_clear;
    logic analog_irq_clear;
  } dpr_cmd_s;

  // One-cycle strobes toward the acquisition logic
  typedef struct packed {
    dpr_cmd_s   cmd;
    logic       counter_ctl_wr;
    logic       cal_key_wr;
    logic       dac_upper_wr;
    logic       dac_sim_update;
    logic [7:0] wr_data;
  } dpr_strobe_s;

  // State shown by the acquisition logic
  typedef struct packed {
    logic [15:0] adc_data;
    logic        adc_busy;
    logic        se_diff;
    logic        adc_wait;
    logic        dac_busy;
    logic [11:0] fifo_depth;
    logic        fifo_over;
    logic        fifo_full;
    logic        fifo_half;
    logic        fifo_empty;
    logic        timer_irq;
    logic        dio_irq;
    logic        analog_irq;
    logic [3:0]  adc_chan;
    logic [7:0]  port_a_in;
    logic [7:0]  port_b_in;
    logic [7:0]  port_c_in;
    logic [23:0] counter_rd;
    logic [7:0]  revision;
    logic        cal_td_busy;
    logic        cal_ee_busy;
    logic        dac_size;
  } dpr_status_s;

  // Configuration held by the window
  typedef struct packed {
    logic [1:0]  bank_sel;
    logic [7:0]  chan_range;
    logic        scan_enable;
    logic [1:0]  adc_gain;
    logic [7:0]  irq_ctrl;
    logic [10:0] fifo_thresh;
    logic [15:0] dac_data;
    logic [1:0]  dac_channel;
    logic [7:0]  port_a_out;
    logic [7:0]  port_b_out;
    logic [7:0]  port_c_out;
    logic [7:0]  dio_dac_ctrl;
    logic [23:0] counter_byte;
    logic [7:0]  cal_data;
    logic [7:0]  cal_addr;
    logic [7:0]  cal_ctrl;
    logic        expanded_fifo_mode;
    logic [7:0]  adc_mode;
    logic [7:0]  dac_mode;
  } dpr_cfg_s;
endpackage : dpr_pkg
`default_nettype wire

// >>> sim/dpr_decoder_sva.sv
// Checker: port-level properties of the paged register window
`default_nettype none
module dpr_decoder_sva
  import dpr_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_window_en,
  input wire logic [2:0]  i_base_sel,
  input wire logic [9:0]  i_sa,
  input wire logic        i_aen,
  input wire logic        i_ior_n,
  input wire logic        i_iow_n,
  input wire logic [7:0]  i_sd,
  input wire logic [7:0]  o_sd,
  input wire logic        o_sd_oe,
  input wire logic        o_claim,
  input wire dpr_status_s i_status,
  input wire dpr_cfg_s    o_cfg,
  input wire dpr_strobe_s o_strobe
);
  logic       live_reg;
  logic [2:0] base_reg;
  logic       iow_q_reg;
  logic [7:0] sd_q_reg;
  dpr_cfg_s   cfg_q_reg;
  logic [9:0] base;
  logic       hit;

  // Strap copy; only the first edge after reset counts
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      live_reg <= 1'b0;
      base_reg <= BASE_SEL_DEFAULT;
    end else if (!live_reg) begin
      live_reg <= 1'b1;
      base_reg <= i_base_sel;
    end
  end

  // Last strobe, data and config, to judge one-edge updates
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      iow_q_reg <= 1'b1;
      sd_q_reg  <= 8'h00;
      cfg_q_reg <= '0;
    end else begin
      iow_q_reg <= i_iow_n;
      sd_q_reg  <= i_sd;
      cfg_q_reg <= o_cfg;
    end
  end

  // Window hit; base is aligned to 0x40 so the low nibble is free
  assign base = BASE_FIRST + BASE_STEP * {7'h00, base_reg};
  assign hit  = live_reg && i_window_en && !i_aen
                && i_sa[9:4] == base[9:4];

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // A write is taken on the first low sample of the strobe
  sequence s_wr(logic [3:0] ofs);
    hit && !i_iow_n && iow_q_reg && i_sa[3:0] == ofs;
  endsequence
  sequence s_paged_wr;
    hit && !i_iow_n && iow_q_reg && i_sa[3:2] == 2'h3;
  endsequence

  a_claim_hit: assert property (live_reg |->
    o_claim == (hit && !(i_ior_n && i_iow_n)))
    else $error("claim does not follow the address hit");
  a_read_lag: assert property (hit && !i_ior_n |=> o_sd_oe)
    else $error("read data not driven one cycle after strobe");
  a_oe_cause: assert property (!o_sd_oe && !(hit && !i_ior_n)
    |=> !o_sd_oe)
    else $error("read data driven without a read hit");
  a_bank_write: assert property (s_wr(OFS_BANK) |=>
    o_cfg.bank_sel == sd_q_reg[1:0])
    else $error("bank select not taken from offset 1");
  a_cmd_pulse: assert property (s_wr(OFS_COMMAND) |=>
    (o_strobe.cmd == {sd_q_reg[7:4], sd_q_reg[2:0]}
     && o_strobe.wr_data == sd_q_reg) ##1 o_strobe.cmd == 7'h00)
    else $error("command strobes wrong or not one cycle");
  a_thr_normal: assert property (s_wr(OFS_THRESH)
    ##0 !o_cfg.expanded_fifo_mode
    |=> o_cfg.fifo_thresh == {5'h00, sd_q_reg[5:0]})
    else $error("six-bit threshold not stored");
  a_thr_expand: assert property (s_wr(OFS_THRESH)
    ##0 o_cfg.expanded_fifo_mode
    |=> o_cfg.fifo_thresh == {sd_q_reg, cfg_q_reg.fifo_thresh[2:0]})
    else $error("expanded threshold bits 10..3 not stored");
  a_irq_mask: assert property (s_wr(OFS_IRQ_CTR) |=>
    o_cfg.irq_ctrl == (sd_q_reg & MASK_IRQ_CTR))
    else $error("interrupt control not masked on write");
  a_no_store: assert property (live_reg && !i_iow_n && !hit
    && !o_strobe.cmd.whole_board_reset |=> $stable(o_cfg))
    else $error("config changed by a write outside the window");
  a_page3_ign: assert property (s_paged_wr
    ##0 o_cfg.bank_sel == 2'h3 |=> $stable(o_cfg))
    else $error("write through unused bank changed config");
endmodule : dpr_decoder_sva

bind dpr_decoder dpr_decoder_sva i_sva (.i_ref_clk, .i_reset,
  .i_window_en, .i_base_sel, .i_sa, .i_aen, .i_ior_n, .i_iow_n,
  .i_sd, .o_sd, .o_sd_oe, .o_claim, .i_status, .o_cfg, .o_strobe);
`default_nettype wire

// >>> sim/dpr_host.sv
// Host model: ISA I/O read and write cycles toward the window
`default_nettype none
module dpr_host (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_sd,
  input  wire logic       i_sd_oe,
  output logic      [9:0] o_sa,
  output logic            o_aen,
  output logic            o_ior_n,
  output logic            o_iow_n,
  output logic      [7:0] o_sd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus, strobes high
  initial begin
    o_sa    = 10'h000;
    o_aen   = 1'b0;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    o_sd    = 8'h00;
  end

  // DMA owns the bus while this is high
  task automatic set_dma(input logic v);
    @(negedge i_ref_clk);
    o_aen = v;
  endtask : set_dma

  // Held through the taking edge, then one high sample before the next
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_sa    = a;
    o_sd    = d;
    o_iow_n = 1'b0;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    o_iow_n = 1'b1;
    o_sd    = ~d;  // Released bus must not keep the old value
    o_sa    = ~a;
    @(posedge i_ref_clk);
  endtask : wr

  // Strobe held until data is seen driven; gives up after four edges
  task automatic rd(input logic [9:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    ok = 1'b0;
    d  = 8'h00;
    @(negedge i_ref_clk);
    o_sa    = a;
    o_ior_n = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge i_ref_clk);
      if (i_sd_oe === 1'b1) begin
        ok = 1'b1;
        d  = i_sd;
      end
    end
    @(negedge i_ref_clk);
    o_ior_n = 1'b1;
    o_sa    = ~a;
    @(posedge i_ref_clk);
  endtask : rd
endmodule : dpr_host
`default_nettype wire

// >>> sim/tb_top.sv
// Testbench: host cycles into the paged register window
`default_nettype none
module tb_top;
  import dpr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic        window_en = 1'b1;
  logic [2:0]  base_sel  = 3'h0;
  logic [9:0]  base      = BASE_FIRST;
  dpr_status_s st        = '0;
  logic [9:0]  sa;
  logic        aen, ior_n, iow_n, sd_oe, claim;
  logic [7:0]  sd_w, sd_r;
  dpr_cfg_s    cfg;
  dpr_strobe_s stb;
  logic        oe_q      = 1'b0;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  logic [7:0]  exp_rd_q[$];
  logic [6:0]  exp_cmd_q[$];
  logic [3:0]  rw_ofs [3] = '{4'h2, 4'h4, 4'hB};
  logic [7:0]  rw_msk [3] = '{8'hFF, MASK_IRQ_CTR, MASK_DIO_DAC};
  logic [7:0]  cmds [7]   = '{8'h80, 8'h20, 8'h10, 8'h04, 8'h02,
                              8'h01, 8'hB7};

  always #5 ref_clk = ~ref_clk;

  dpr_decoder i_dut (
    .i_ref_clk  (ref_clk),
    .i_reset    (reset),
    .i_window_en(window_en),
    .i_base_sel (base_sel),
    .i_sa       (sa),
    .i_aen      (aen),
    .i_ior_n    (ior_n),
    .i_iow_n    (iow_n),
    .i_sd       (sd_w),
    .o_sd       (sd_r),
    .o_sd_oe    (sd_oe),
    .o_claim    (claim),
    .i_status   (st),
    .o_cfg      (cfg),
    .o_strobe   (stb)
  );

  dpr_host i_host (
    .i_ref_clk(ref_clk),
    .i_sd     (sd_r),
    .i_sd_oe  (sd_oe),
    .o_sa     (sa),
    .o_aen    (aen),
    .o_ior_n  (ior_n),
    .o_iow_n  (iow_n),
    .o_sd     (sd_w)
  );

  task automatic cmp_byte(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_val(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp_val

  // Oldest note is matched against each new read or command pulse
  always @(posedge ref_clk) begin
    if (sd_oe === 1'b1 && oe_q !== 1'b1)
      cmp_byte("read", exp_rd_q.size() ? exp_rd_q.pop_front() : 8'hXX,
               sd_r);
    if (stb.cmd !== 7'h00)
      cmp_byte("cmd", {1'b0, exp_cmd_q.size() ? exp_cmd_q.pop_front()
               : 7'h7F}, {1'b0, stb.cmd});
    oe_q = sd_oe;
  end

  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    i_host.wr(base + {6'h00, o}, d);
  endtask : wr

  task automatic rdc(input logic [3:0] o, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    exp_rd_q.push_back(e);
    i_host.rd(base + {6'h00, o}, d, ok);
    cmp_val("read_ack", 32'h1, {31'h0, ok});
  endtask : rdc

  // A read nobody may answer
  task automatic miss(input logic [9:0] a);
    logic [7:0] d;
    logic       ok;
    i_host.rd(a, d, ok);
    cmp_val("refused_ack", 32'h0, {31'h0, ok});
  endtask : miss

  // Base strap is only looked at just after release
  task automatic do_reset(input logic [2:0] s);
    @(negedge ref_clk);
    reset    = 1'b1;
    base_sel = s;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    base  = BASE_FIRST + BASE_STEP * {7'h00, s};
    repeat (2) @(negedge ref_clk);
  endtask : do_reset

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Whole run is about 200 cycles; give it ample margin
  initial begin
    #100_000;
    n_mismatch++;
    conclude();
  end

  initial begin
    int          i;
    logic [7:0]  d, e;
    logic [11:0] dac;
    logic [127:0] rnd;
    i   = $urandom(32'hF19D);
    rnd = {$urandom, $urandom, $urandom, $urandom};
    st  = dpr_status_s'(rnd[$bits(dpr_status_s)-1:0]);
    do_reset(3'($urandom_range(7, 0)));
    // Read-back registers, all ones first to hit reserved bits
    for (i = 0; i < 6; i++) begin
      d = (i < 3) ? 8'hFF : 8'($urandom);
      wr(rw_ofs[i%3], d);
      rdc(rw_ofs[i%3], d & rw_msk[i%3]);
    end
    d = 8'($urandom);
    wr(4'h3, d);
    cmp_val("gain", {29'h0, d[2:0]}, {29'h0, cfg.scan_enable, cfg.adc_gain});
    rdc(4'h3, {st.adc_busy, st.se_diff, st.adc_wait, st.dac_busy,
               st.fifo_over, d[2:0]});
    d = 8'($urandom);
    e = 8'($urandom);
    dac = {e[3:0], d};
    wr(4'h6, d);
    wr(4'h7, e);
    cmp_val("dac", {18'h0, e[7:6], dac}, {18'h0, cfg.dac_channel, cfg.dac_data[11:0]});
    rdc(4'h6, {2'h0, st.fifo_depth[5:0]});
    rdc(4'h7, {1'b0, st.timer_irq, st.dio_irq, st.analog_irq,
               st.adc_chan});
    for (i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(4'h8 + 4'(i), d);
      cmp_val("port_out", {24'h0, d}, {24'h0, cfg[96 - 8*i -: 8]});
      rdc(4'h8 + 4'(i), st[58 - 8*i -: 8]);
    end
    d = 8'($urandom);
    wr(4'h5, d);
    rdc(4'h5, {2'h0, d[5:0]});
    // Counter bank
    wr(OFS_BANK, 8'hFC);
    for (i = 0; i < 3; i++) begin
      e = 8'($urandom);
      wr(4'hC + 4'(i), e);
      cmp_val("counter", {24'h0, e}, {24'h0, cfg.counter_byte[8*i +: 8]});
      rdc(4'hC + 4'(i), st.counter_rd[8*i +: 8]);
    end
    rdc(4'hF, st.revision);
    // Calibration bank
    wr(OFS_BANK, 8'h01);
    e = 8'($urandom);
    wr(4'hC, e);
    wr(4'hD, ~e);
    rdc(4'hC, e);
    rdc(4'hD, ~e);
    wr(4'hE, 8'hFF);
    cmp_val("cal_ctrl", 32'hF8, {24'h0, cfg.cal_ctrl});
    rdc(4'hE, {1'b0, st.cal_td_busy, st.cal_ee_busy, 5'h10});
    // Unused bank: nothing stored, reads zero
    wr(OFS_BANK, 8'h03);
    wr(4'hC, 8'hFF);
    rdc(4'hC, 8'h00);
    // Configuration bank, then the expanded threshold
    wr(OFS_BANK, 8'h02);
    wr(4'hC, 8'hFF);
    wr(4'hD, 8'hFF);
    wr(4'hE, 8'hFF);
    cmp_val("modes", {15'h0, 1'b1, MASK_ADC_MODE, MASK_DAC_MODE}, {15'h0, cfg.expanded_fifo_mode, cfg.adc_mode, cfg.dac_mode});
    e = 8'($urandom);
    wr(4'h5, e);
    cmp_val("thresh", {21'h0, e, d[2:0]}, {21'h0, cfg.fifo_thresh});
    rdc(4'h5, st.fifo_depth[7:0]);
    rdc(4'h6, {st.fifo_depth[11:8], st.fifo_over, st.fifo_full,
               st.fifo_half, st.fifo_empty});
    rdc(4'hF, 8'h00);
    // Upper D/A byte overlaps bits 11..8 written at offset 7
    wr(4'hF, e);
    dac[11:8] = e[3:0];
    cmp_val("dac_upper", {24'h0, e}, {24'h0, cfg.dac_data[15:8]});
    // Refused cycles
    wr(4'h2, 8'hA5);
    @(negedge ref_clk);
    window_en = 1'b0;
    miss(base + 10'h002);
    wr(4'h2, 8'h5A);
    cmp_val("chan_range", 32'hA5, {24'h0, cfg.chan_range});
    @(negedge ref_clk);
    window_en = 1'b1;
    i_host.set_dma(1'b1);
    miss(base + 10'h002);
    i_host.set_dma(1'b0);
    miss(base ^ 10'h040);
    // Each trigger alone, then several together, then board reset
    for (i = 0; i < 7; i++) begin
      exp_cmd_q.push_back({cmds[i][7:4], cmds[i][2:0]});
      wr(OFS_COMMAND, cmds[i]);
    end
    exp_cmd_q.push_back(7'h20);
    wr(OFS_COMMAND, 8'h40);
    repeat (3) @(negedge ref_clk);
    cmp_val("board_reset", {8'h0, 12'h000, dac}, {8'h0, cfg.chan_range, 4'h0, cfg.dac_data[11:0]});
    do_reset(3'h0);
    wr(4'h2, 8'h3C);
    rdc(4'h2, 8'h3C);
    repeat (3) @(negedge ref_clk);
    cmp_val("pending", 32'h0, exp_rd_q.size() + exp_cmd_q.size());
    conclude();
  end
endmodule : tb_top
`default_nettype wire
